// ---- inc/ocdf_params.svh ----
// Contract
// RULE1 - Eight independent channels digitize their inputs in parallel, each with its own filter.
// RULE2 - Each modulator ones-density stream feeds its channel filter, which yields the result.
// RULE3 - High-speed, low-power and low-speed modes share one filter decimating by 64.
// RULE4 - High-resolution mode decimates by 128.
// RULE5 - The filter is a multi-stage linear-phase FIR with constant group delay.
// RULE6 - The stop band attenuates by 100 dB from just past the passband up to the modulator rate; the default COEFS taps fall short of it.
// RULE7 - All channel filters start convolution on the same modulator cycle.
// RULE8 - Every channel's modulator sampling instant comes from the one master clock.
// RULE9 - A bypass path hands out raw modulator bits instead of decimated results.
// RULE10 - Mode and configuration come only from pins; nothing is programmable by software.
// RULE11 - At the top output rate in high-speed mode the receiver uses frame-sync format; the code has no serial interface, only parallel outputs.
// RULE12 - Four modes are selectable: high-speed, high-resolution, low-power, low-speed.
// RULE13 - Modulator divisor: 4 in high-speed and high-res, 8 or 4 low-power, 40 or 8 low-speed.
// RULE14 - Results are 24-bit two's complement and saturate at the extreme codes.
// RULE15 - Results count as settled after 76 conversions, or 78 in high-resolution mode.
// RULE16 - Coefficients are a parameter set, and all channels emit results together.
// RULE17 - Data ready pulses once per output period when all eight results update together.
`ifndef OCDF_PARAMS_SVH
`define OCDF_PARAMS_SVH

// Modulator clock divisors
`define OCDF_DIV_FAST     6'h04
`define OCDF_DIV_LP_HI    6'h08
`define OCDF_DIV_LP_LO    6'h04
`define OCDF_DIV_LS_HI    6'h28
`define OCDF_DIV_LS_LO    6'h08

// Oversampling ratios and first-stage decimation
`define OCDF_OSR_STD      8'h40
`define OCDF_OSR_HR       8'h80
`define OCDF_S1_STD       7'h20
`define OCDF_S1_HR        7'h40
// Left shift that brings a third-order sinc output to full scale
`define OCDF_NORM_STD     8
`define OCDF_NORM_HR      5

// Settling, in conversion periods
`define OCDF_SETTLE_STD   7'h4C
`define OCDF_SETTLE_HR    7'h4E

// Result format
`define OCDF_RES_W        24
`define OCDF_RES_MAX      24'h7FFFFF
`define OCDF_RES_MIN      24'h800000

// Register offsets (byte addresses)
`define OCDF_ADR_RES0     8'h00
`define OCDF_ADR_STATUS   8'h20
`define OCDF_ADR_RAW      8'h24
`define OCDF_ADR_W        8

// Status field positions
`define OCDF_ST_SETTLED   0
`define OCDF_ST_BYPASS    1
`define OCDF_ST_DIVSEL    2
`define OCDF_ST_MODE_LO   4

`endif

// ---- inc/ocdf_pkg.sv ----
package ocdf_pkg;

   // Operating mode as strapped on the mode pins
   typedef enum logic [1:0] {
      OCDF_HIGH_SPEED = 2'b00,
      OCDF_HIGH_RES   = 2'b01,
      OCDF_LOW_POWER  = 2'b10,
      OCDF_LOW_SPEED  = 2'b11
   } ocdf_mode_t;

   // Filter run state
   typedef enum logic [0:0] {
      OCDF_HALT = 1'b0,
      OCDF_RUN  = 1'b1
   } ocdf_state_t;

endpackage

// ---- hdl/ocdf_octal_decimator.sv ----
// Implementation choices: the register addresses and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "ocdf_params.svh"

module ocdf_octal_decimator #(
   parameter int                     NCH        = 8,
   parameter int                     TAPS       = 7,
   parameter int                     COEF_W     = 16,
   parameter int                     COEF_SHIFT = 6,
   // Symmetric half-band style taps, sum 2**COEF_SHIFT
   parameter logic [TAPS*COEF_W-1:0] COEFS      = {16'hFFFE, 16'h0000, 16'h0012,
                                                   16'h0020, 16'h0012, 16'h0000,
                                                   16'hFFFE}
) (
   input  wire logic                 clk,
   input  wire logic                 resetn,
   input  wire logic [NCH-1:0]       modBits,
   input  wire logic [1:0]           modeSel,
   input  wire logic                 clockDivideSelect,
   input  wire logic                 bypassEnable,
   input  wire logic                 syncRequestN,
   output logic                      modClkEn,
   output logic                      dataReady,
   output logic [NCH*24-1:0]         results,
   output logic                      rawValid,
   output logic [NCH-1:0]            rawBits,
   output logic                      resultSettled,
   input  wire logic [7:0]           wb_adr_i,
   input  wire logic [31:0]          wb_dat_i,
   input  wire logic                 wb_we_i,
   input  wire logic [3:0]           wb_sel_i,
   input  wire logic                 wb_cyc_i,
   input  wire logic                 wb_stb_i,
   output logic [31:0]               wb_dat_o,
   output logic                      wb_ack_o
);

   localparam int PW  = NCH + 5;
   localparam int S1W = 26;
   localparam int HW  = 25;
   localparam int AW  = HW + COEF_W + 4;

   // Elaboration checks
   if (NCH < 1 || NCH > 8) begin : gNchCheck
      $error("NCH must be 1 to 8");
   end
   if (TAPS < 1 || COEF_SHIFT < 0 || COEF_SHIFT >= AW) begin : gTapCheck
      $error("Bad tap count or coefficient shift");
   end

   // Divisor from mode and divide pin
   function automatic logic [5:0] modDivisor(input ocdf_pkg::ocdf_mode_t m,
                                             input logic ds);
      case (m)
         ocdf_pkg::OCDF_LOW_POWER: modDivisor = ds ? `OCDF_DIV_LP_HI : `OCDF_DIV_LP_LO;
         ocdf_pkg::OCDF_LOW_SPEED: modDivisor = ds ? `OCDF_DIV_LS_HI : `OCDF_DIV_LS_LO;
         default:                  modDivisor = `OCDF_DIV_FAST;
      endcase
   endfunction

   // Mode decode reused by several stages
   function automatic logic isHighRes(input ocdf_pkg::ocdf_mode_t m);
      isHighRes = (m == ocdf_pkg::OCDF_HIGH_RES);
   endfunction

   // Clip a wide accumulator to the 24-bit code range
   function automatic logic [23:0] clip24(input logic signed [AW-1:0] v);
      if (v > $signed({{(AW-24){1'b0}}, `OCDF_RES_MAX}))
         clip24 = `OCDF_RES_MAX;
      else if (v < $signed({{(AW-24){1'b1}}, `OCDF_RES_MIN}))
         clip24 = `OCDF_RES_MIN;
      else
         clip24 = v[23:0];
   endfunction

   // Pin synchronisers: every modulator, mode, divide, bypass and sync pin is asynchronous to clk
   logic [PW-1:0] pinMeta_r;
   logic [PW-1:0] pinSync_r;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pinMeta_r <= '0;
         pinSync_r <= '0;
      end else begin
         pinMeta_r <= {modBits, modeSel, clockDivideSelect, bypassEnable, syncRequestN};
         pinSync_r <= pinMeta_r;
      end
   end

   logic [NCH-1:0]       modS;
   ocdf_pkg::ocdf_mode_t modeS;
   logic                 divSelS;
   logic                 bypassS;
   logic                 syncNS;
   assign modS    = pinSync_r[PW-1:5];
   assign modeS   = ocdf_pkg::ocdf_mode_t'(pinSync_r[4:3]);  // RULE12
   assign divSelS = pinSync_r[2];
   assign bypassS = pinSync_r[1];
   assign syncNS  = pinSync_r[0];

   // Configuration latch; any mode or divide-select change restarts the chain
   logic [2:0] cfgLast_r;
   logic       cfgChange;
   logic       restart;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn)
         cfgLast_r <= 3'h0;
      else
         cfgLast_r <= {modeS, divSelS};
   end
   assign cfgChange = (cfgLast_r != {modeS, divSelS});
   assign restart   = !syncNS || cfgChange;  // RULE10

   // Run state: held while sync is low, then every channel starts together
   ocdf_pkg::ocdf_state_t state_r;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_r <= ocdf_pkg::OCDF_HALT;
      end else begin
         case (state_r)
            ocdf_pkg::OCDF_HALT: if (!restart) state_r <= ocdf_pkg::OCDF_RUN;
            ocdf_pkg::OCDF_RUN:  if (restart) state_r <= ocdf_pkg::OCDF_HALT;
            default:             state_r <= ocdf_pkg::OCDF_HALT;
         endcase
      end
   end

   // Modulator rate divider from the master clock
   logic [5:0] divCnt_r;
   logic [5:0] divisor;
   logic       modTick;
   assign divisor = modDivisor(modeS, divSelS);  // RULE13
   assign modTick = (state_r == ocdf_pkg::OCDF_RUN) && (divCnt_r == divisor - 6'h01);
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn)
         divCnt_r <= 6'h00;
      else if (restart || modTick)
         divCnt_r <= 6'h00;  // RULE8
      else if (state_r == ocdf_pkg::OCDF_RUN)
         divCnt_r <= divCnt_r + 6'h01;
   end
   assign modClkEn = modTick;  // RULE8

   // Shared decimation phase keeps all channels aligned
   logic [6:0] s1Len;
   logic [6:0] decCnt_r;
   logic       halfPh_r;
   logic       s1Wrap;
   logic       outStrobe;
   assign s1Len     = isHighRes(modeS) ? `OCDF_S1_HR : `OCDF_S1_STD;  // RULE3 RULE4
   assign s1Wrap    = modTick && (decCnt_r == s1Len - 7'h01);
   assign outStrobe = s1Wrap && halfPh_r;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         decCnt_r <= 7'h00;
         halfPh_r <= 1'b0;
      end else if (restart) begin
         decCnt_r <= 7'h00;  // RULE7
         halfPh_r <= 1'b0;
      end else if (modTick) begin
         decCnt_r <= s1Wrap ? 7'h00 : decCnt_r + 7'h01;
         if (s1Wrap)
            halfPh_r <= !halfPh_r;
      end
   end

   // Second stage fires one cycle after its history shifts
   logic firGo_r;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn)
         firGo_r <= 1'b0;
      else
         firGo_r <= outStrobe && !restart;
   end

   logic [4:0] normShift;
   assign normShift = isHighRes(modeS) ? 5'(`OCDF_NORM_HR) : 5'(`OCDF_NORM_STD);

   // One filter per channel: third-order sinc then symmetric FIR by two
   genvar ch;
   for (ch = 0; ch < NCH; ch++) begin : gChan  // RULE1
      logic signed [S1W-1:0] int1_r, int2_r, int3_r;
      logic signed [S1W-1:0] comb1_r, comb2_r, comb3_r;
      logic signed [S1W-1:0] d1, d2, d3;
      logic signed [S1W-1:0] xIn;
      logic signed [HW-1:0]  s1Norm;
      logic signed [HW-1:0]  hist_r [TAPS];
      logic signed [AW-1:0]  acc;
      logic [23:0]           res_r;

      // Ones-density bit maps to plus or minus one
      assign xIn = modS[ch] ? S1W'(1) : -S1W'(1);  // RULE2

      // Integrators at modulator rate; wrap-around is harmless in sinc form
      always_ff @(posedge clk or negedge resetn) begin
         if (!resetn) begin
            int1_r <= '0;
            int2_r <= '0;
            int3_r <= '0;
         end else if (restart) begin
            int1_r <= '0;
            int2_r <= '0;
            int3_r <= '0;
         end else if (modTick) begin
            int1_r <= int1_r + xIn;  // RULE5
            int2_r <= int2_r + int1_r;
            int3_r <= int3_r + int2_r;
         end
      end

      // Combs at the first-stage output rate
      assign d1 = int3_r - comb1_r;
      assign d2 = d1 - comb2_r;
      assign d3 = d2 - comb3_r;
      always_ff @(posedge clk or negedge resetn) begin
         if (!resetn) begin
            comb1_r <= '0;
            comb2_r <= '0;
            comb3_r <= '0;
         end else if (restart) begin
            comb1_r <= '0;
            comb2_r <= '0;
            comb3_r <= '0;
         end else if (s1Wrap) begin
            comb1_r <= int3_r;
            comb2_r <= d1;
            comb3_r <= d2;
         end
      end

      // Scale to full-scale code; one spare bit holds +2**23
      assign s1Norm = HW'(d3 <<< normShift);

      // Second-stage history line
      always_ff @(posedge clk or negedge resetn) begin
         if (!resetn) begin
            for (int t = 0; t < TAPS; t++)
               hist_r[t] <= '0;
         end else if (restart) begin
            for (int t = 0; t < TAPS; t++)
               hist_r[t] <= '0;
         end else if (s1Wrap) begin
            hist_r[0] <= s1Norm;
            for (int t = 1; t < TAPS; t++)
               hist_r[t] <= hist_r[t-1];
         end
      end

      // Tap sum; symmetric taps give constant group delay
      // Stop-band depth rests on the COEFS set; the default taps fall short
      always_comb begin  // RULE6
         acc = '0;
         for (int t = 0; t < TAPS; t++)
            acc = acc + AW'(hist_r[t]) * AW'($signed(COEFS[t*COEF_W +: COEF_W]));  // RULE16
      end

      // Result register, clipped to 24-bit code range
      always_ff @(posedge clk or negedge resetn) begin
         if (!resetn)
            res_r <= 24'h000000;
         else if (firGo_r)
            res_r <= clip24(acc >>> COEF_SHIFT);  // RULE14
      end
      assign results[ch*24 +: 24] = res_r;  // RULE16
   end

   // Data ready once per output period; silent in bypass
   logic dataReady_r;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn)
         dataReady_r <= 1'b0;
      else
         dataReady_r <= firGo_r && !bypassS;  // RULE17
   end
   assign dataReady = dataReady_r;

   // Raw modulator bits handed out in bypass
   logic [NCH-1:0] rawBits_r;
   logic           rawValid_r;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rawBits_r  <= '0;
         rawValid_r <= 1'b0;
      end else begin
         rawValid_r <= modTick && bypassS;  // RULE9
         if (modTick)
            rawBits_r <= modS;
      end
   end
   assign rawBits  = rawBits_r;
   assign rawValid = rawValid_r;

   // Settling count, restarted with the filter
   logic [6:0] settleCnt_r;
   logic [6:0] settleTgt;
   assign settleTgt = isHighRes(modeS) ? `OCDF_SETTLE_HR : `OCDF_SETTLE_STD;
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn)
         settleCnt_r <= 7'h00;
      else if (restart)
         settleCnt_r <= 7'h00;
      else if (firGo_r && settleCnt_r != settleTgt)
         settleCnt_r <= settleCnt_r + 7'h01;  // RULE15
   end
   assign resultSettled = (settleCnt_r == settleTgt);

   // Wishbone slave: read-only view, writes acked and dropped
   logic        ack_r;
   logic [31:0] rdData_r;
   logic [31:0] rdMux;
   logic [2:0]  rdIdx;
   assign rdIdx = wb_adr_i[4:2];
   always_comb begin
      rdMux = 32'h00000000;
      if (wb_adr_i < `OCDF_ADR_STATUS && wb_adr_i[1:0] == 2'b00) begin
         if (32'(rdIdx) < NCH)
            rdMux = {8'h00, results[rdIdx*24 +: 24]};
      end else if (wb_adr_i == `OCDF_ADR_STATUS) begin
         rdMux[`OCDF_ST_SETTLED]                   = resultSettled;
         rdMux[`OCDF_ST_BYPASS]                    = bypassS;
         rdMux[`OCDF_ST_DIVSEL]                    = divSelS;
         rdMux[`OCDF_ST_MODE_LO +: 2]              = modeS;
      end else if (wb_adr_i == `OCDF_ADR_RAW) begin
         rdMux[NCH-1:0] = rawBits_r;
      end
   end

   // One-cycle answer; ack drops the cycle after it was given
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ack_r    <= 1'b0;
         rdData_r <= 32'h00000000;
      end else begin
         ack_r <= wb_cyc_i && wb_stb_i && !ack_r;
         if (wb_cyc_i && wb_stb_i && !ack_r && !wb_we_i)
            rdData_r <= rdMux;  // RULE10
      end
   end
   assign wb_ack_o = ack_r;
   assign wb_dat_o = rdData_r;

endmodule

// ---- sim/ocdf_mod_model.sv ----
`timescale 1ns/1ps
// Eight modulators, each holding a steady ones density
// Serial receiver not modelled; at the top high-speed rate it takes frame-sync form
module ocdf_mod_model (
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic       modClkEn,
   input  wire logic [7:0] density,
   output logic      [7:0] modBits
);
   // One shared strobe steps all streams, so no channel leads another
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         modBits <= 8'h00;
      end else if (modClkEn) begin
         modBits <= density;
      end
   end
endmodule

// ---- sim/ocdf_chk.sv ----
`timescale 1ns/1ps
module ocdf_chk #(
   parameter int NCH = 8
) (
   input wire logic           clk,
   input wire logic           resetn,
   input wire logic           syncRequestN,
   input wire logic           modClkEn,
   input wire logic           dataReady,
   input wire logic           rawValid,
   input wire logic [NCH-1:0] rawBits,
   input wire logic           wb_cyc_i,
   input wire logic           wb_stb_i,
   input wire logic           wb_ack_o
);
   logic [9:0] drGap_r;
   // Clocks since last ready, saturating so a first pulse always passes
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         drGap_r <= 10'h3FF;
      end else if (dataReady) begin
         drGap_r <= 10'h000;
      end else if (drGap_r != 10'h3FF) begin
         drGap_r <= drGap_r + 10'h001;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   property p_ackNext; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
   a_ackNext: assert property (p_ackNext) else $error("ack late");
   property p_ackOnce; wb_ack_o |=> !wb_ack_o; endproperty
   a_ackOnce: assert property (p_ackOnce) else $error("ack too long");
   property p_drPulse; dataReady |=> !dataReady; endproperty
   a_drPulse: assert property (p_drPulse) else $error("ready too long");
   property p_drGap; dataReady |-> drGap_r >= 10'h0FF; endproperty
   a_drGap: assert property (p_drGap) else $error("ready too soon");
   property p_clkGap; modClkEn |=> !modClkEn [*3]; endproperty
   a_clkGap: assert property (p_clkGap) else $error("strobe too soon");
   property p_rawAfter; rawValid |-> $past(modClkEn); endproperty
   a_rawAfter: assert property (p_rawAfter) else $error("raw strobe astray");
   property p_rawHold; !$stable(rawBits) |-> $past(modClkEn); endproperty
   a_rawHold: assert property (p_rawHold) else $error("raw bits moved");
   property p_syncHold; !syncRequestN [*5] |-> !modClkEn && !dataReady; endproperty
   a_syncHold: assert property (p_syncHold) else $error("ran in restart");
endmodule

bind ocdf_octal_decimator ocdf_chk #(.NCH(NCH)) u_chk (.*);

// ---- sim/octal_decimation_filter_test.sv ----
`timescale 1ns/1ps
module octal_decimation_filter_test;
   logic         clk, resetn, clockDivideSelect, bypassEnable, syncRequestN;
   logic         modClkEn, dataReady, rawValid, resultSettled;
   logic         wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
   logic [1:0]   modeSel;
   logic [3:0]   wb_sel_i;
   logic [7:0]   modBits, rawBits, density, wb_adr_i;
   logic [31:0]  wb_dat_i, wb_dat_o, q, e;
   logic [191:0] results;
   int           fail_count, checks_done, p, n;
   // Mode, divide select and divisor for each strap setting
   logic [1:0]   mTab [6] = '{2'b00, 2'b01, 2'b10, 2'b10, 2'b11, 2'b11};
   logic         vTab [6] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b0};
   int           dTab [6] = '{4, 4, 8, 4, 40, 8};

   ocdf_octal_decimator u_dut (
      .clk, .resetn, .modBits, .modeSel, .clockDivideSelect, .bypassEnable,
      .syncRequestN, .modClkEn, .dataReady, .results, .rawValid, .rawBits,
      .resultSettled, .wb_adr_i, .wb_dat_i, .wb_we_i, .wb_sel_i, .wb_cyc_i,
      .wb_stb_i, .wb_dat_o, .wb_ack_o
   );
   ocdf_mod_model u_mod (.clk, .resetn, .modClkEn, .density, .modBits);

   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("FAIL %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic close_out();
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // A wait that ran dry counts against the run and ends it
   task automatic hang();
      check("wait", 32'h1, 32'h0);
      close_out();
   endtask

   // Classic cycle; request held until the edge that shows ack
   task automatic wb(input logic [7:0] a, input logic w, input logic [31:0] d);
      n = 0;
      wb_adr_i <= a;
      wb_we_i <= w;
      wb_dat_i <= d;
      wb_sel_i <= 4'hF;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      if (wb_ack_o !== 1'b1) hang();
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      @(posedge clk);
   endtask

   // Clocks between two successive strobes of ready or modulator enable
   task automatic period(input logic dr);
      int first;
      first = -1;
      p = 0;
      n = 0;
      while (p == 0 && n < 8000) begin
         @(posedge clk);
         n++;
         if ((dr ? dataReady : modClkEn) === 1'b1) begin
            if (first < 0) first = n;
            else p = n - first;
         end
      end
      if (p == 0) hang();
   endtask

   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   initial begin
      {resetn, bypassEnable, wb_we_i, wb_cyc_i, wb_stb_i, modeSel} = '0;
      {clockDivideSelect, syncRequestN} = 2'b11;
      {wb_adr_i, wb_dat_i, wb_sel_i, density} = {8'h00, 32'h0, 4'hF, 8'hA5};
      {fail_count, checks_done} = '0;
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
      @(posedge clk);
      wb(8'h30, 1'b0, 32'h0);
      check("unmapped", q, 32'h0);
      wb(8'h20, 1'b1, 32'hFFFFFFFF);
      // Six strap settings, every mode and divisor: strobe spacing, output spacing, pin status
      for (int i = 0; i < 6; i++) begin
         modeSel <= mTab[i];
         clockDivideSelect <= vTab[i];
         repeat (4) @(posedge clk);
         period(1'b0);
         check("mod period", p, dTab[i]);
         period(1'b1);
         check("ready period", p, dTab[i] * (mTab[i] == 2'b01 ? 128 : 64));
         wb(8'h20, 1'b0, 32'h0);
         check("status", q, {26'h0, mTab[i], 1'b0, vTab[i], 2'b00});
      end
      // Restart in high-speed, then high-resolution; count outputs until settled
      for (int r = 0; r < 2; r++) begin
         modeSel <= 2'(r);
         clockDivideSelect <= 1'b1;
         syncRequestN <= 1'b0;
         repeat (8) @(posedge clk);
         syncRequestN <= 1'b1;
         p = 0;
         n = 0;
         while (resultSettled !== 1'b1 && n < 50000) begin
            @(posedge clk);
            n++;
            if (dataReady === 1'b1) p++;
         end
         if (resultSettled !== 1'b1) hang();
         check("outputs to settle", p, (r == 1) ? 32'h4E : 32'h4C);
         for (int c = 0; c < 8; c++) begin
            e = density[c] ? 32'h007FFFFF : 32'h00800000;
            check("result port", {8'h00, results[c*24 +: 24]}, e);
            wb(8'(c * 4), 1'b0, 32'h0);
            check("result reg", q, e);
         end
         wb(8'h20, 1'b0, 32'h0);
         check("status settled", q, {26'h0, 2'(r), 4'h5});
      end
      // Bypass: raw bits flow, ready stays quiet
      bypassEnable <= 1'b1;
      density <= 8'h3C;
      repeat (20) @(posedge clk);
      p = 0;
      n = 0;
      repeat (600) begin
         @(posedge clk);
         if (dataReady === 1'b1) p++;
         if (rawValid === 1'b1) n++;
      end
      check("ready in bypass", p, 32'h0);
      check("raw strobes", n, 32'h96);
      check("raw bits", {24'h0, rawBits}, 32'h3C);
      wb(8'h24, 1'b0, 32'h0);
      check("raw reg", q, 32'h3C);
      close_out();
   end
endmodule
